// ---- rtl/ocu_defs.vh ----
/*
  Constants of the two-channel 16-bit output compare unit: waveform modes,
  fixed TOP values, output action codes and reset values.
  Assumes inclusion by bare name from the rtl files of this block.
*/
`ifndef OCU_DEFS_VH
`define OCU_DEFS_VH

// ==========================================================================
// waveform mode select codes
`define OCU_MODE_NORMAL     4'h0
`define OCU_MODE_PC8        4'h1
`define OCU_MODE_PC9        4'h2
`define OCU_MODE_PC10       4'h3
`define OCU_MODE_CTC_CMPA   4'h4
`define OCU_MODE_FAST8      4'h5
`define OCU_MODE_FAST9      4'h6
`define OCU_MODE_FAST10     4'h7
`define OCU_MODE_PFC_CAP    4'h8
`define OCU_MODE_PFC_CMPA   4'h9
`define OCU_MODE_PC_CAP     4'ha
`define OCU_MODE_PC_CMPA    4'hb
`define OCU_MODE_CTC_CAP    4'hc
`define OCU_MODE_RSVD       4'hd
`define OCU_MODE_FAST_CAP   4'he
`define OCU_MODE_FAST_CMPA  4'hf

// ==========================================================================
// counter limits
`define OCU_MAX             16'hffff
`define OCU_BOTTOM          16'h0000
`define OCU_TOP8            16'h00ff
`define OCU_TOP9            16'h01ff
`define OCU_TOP10           16'h03ff

// ==========================================================================
// output action codes
`define OCU_ACT_NONE        2'h0
`define OCU_ACT_TOGGLE      2'h1
`define OCU_ACT_CLEAR       2'h2
`define OCU_ACT_SET         2'h3

// ==========================================================================
// reset values
`define OCU_RST_COUNT       16'h0000
`define OCU_RST_CMP         16'h0000
`define OCU_RST_TEMP        8'h00
`define OCU_RST_STATE       1'b0

`endif

// ---- rtl/ocu_cmp_reg.v ----
/*
  Compare value storage of one channel: CPU-visible buffer plus the
  compare register that the comparator sees.
  Assumes the writer assembles the 16-bit word from the shared high-byte
  latch and gives one-cycle load events on the same clock.
*/
`default_nettype none
`include "ocu_defs.vh"

module ocu_cmp_reg (
  input  wire        mclk,      // system clock
  input  wire        arst_n,    // async reset, active low
  input  wire        wrLow,     // low-byte write strobe, completes the word
  input  wire [15:0] wrWord,    // latched high byte and new low byte
  input  wire [15:0] topMask,   // unused bits of a fixed TOP are masked
  input  wire        dblBuf,    // double buffering active
  input  wire        loadEvt,   // TOP or BOTTOM update point
  output reg  [15:0] bufValue,  // value the CPU reads back
  output reg  [15:0] cmpValue   // value the comparator uses
);

  wire [15:0] maskedWord;

  assign maskedWord = wrWord & topMask;

  // ========================================================================
  // buffer: holds what the CPU wrote last, masked by topMask
  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      bufValue <= `OCU_RST_CMP;
    else if (wrLow)
      bufValue <= maskedWord;
  end

  // ========================================================================
  // compare register: direct write or update at TOP or BOTTOM
  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      cmpValue <= `OCU_RST_CMP;
    else if (wrLow && !dblBuf)
      cmpValue <= maskedWord;
    else if (dblBuf && loadEvt)
      cmpValue <= bufValue;
  end

endmodule
`default_nettype wire

// ---- rtl/ocu_timer.v ----
/*
  Two-channel output compare unit with its 16-bit counter: counting
  sequences, compare matches, match and overflow flags, output states and
  pin override for channels A and B.
  Assumes the CPU side gives one-cycle write strobes on mclk, the prescaler
  gives a one-cycle count enable on mclk, and port logic sits outside.
*/
`default_nettype none
`include "ocu_defs.vh"

module ocu_timer (
  input  wire        mclk,              // system clock, 40 MHz
  input  wire        arst_n,            // async reset, active low
  input  wire        timerClkEn,        // one-cycle timer clock enable
  input  wire [7:0]  cpuWrData,         // CPU write data
  input  wire        wrCountHigh,       // write strobe, counter high byte
  input  wire        wrCountLow,        // write strobe, counter low byte
  input  wire        wrCompareHighA,    // write strobe, compare_value_high A
  input  wire        wrCompareLowA,     // write strobe, compare_value_low A
  input  wire        wrCompareHighB,    // write strobe, compare_value_high B
  input  wire        wrCompareLowB,     // write strobe, compare_value_low B
  input  wire [3:0]  waveformModeSelect, // counting and waveform mode
  input  wire [1:0]  outputActionBitsA, // output action, channel A
  input  wire [1:0]  outputActionBitsB, // output action, channel B
  input  wire        forceMatchStrobeA, // force strobe A, one cycle
  input  wire        forceMatchStrobeB, // force strobe B, one cycle
  input  wire        compareIrqEnableA, // match interrupt enable A
  input  wire        compareIrqEnableB, // match interrupt enable B
  input  wire        overflowIrqEnable, // overflow interrupt enable
  input  wire        clrMatchFlagA,     // CPU writes one to flag A
  input  wire        clrMatchFlagB,     // CPU writes one to flag B
  input  wire        clrOverflowFlag,   // CPU writes one to overflow flag
  input  wire        irqAckA,           // match interrupt A serviced
  input  wire        irqAckB,           // match interrupt B serviced
  input  wire        irqAckOvf,         // overflow interrupt serviced
  input  wire [15:0] captureValue,      // capture register, used as TOP
  input  wire        portValueA,        // normal port output value, pin A
  input  wire        portValueB,        // normal port output value, pin B
  input  wire        outputPinDirA,     // port direction A, 1 = output
  input  wire        outputPinDirB,     // port direction B, 1 = output
  output reg  [15:0] timerCount,        // counter value
  output wire [15:0] compareValueA,     // CPU read view, compare A
  output wire [15:0] compareValueB,     // CPU read view, compare B
  output reg         compareMatchFlagA, // match flag A
  output reg         compareMatchFlagB, // match flag B
  output reg         overflowFlag,      // overflow flag
  output wire        compareIrqA,       // interrupt request A
  output wire        compareIrqB,       // interrupt request B
  output wire        overflowIrq,       // overflow interrupt request
  output wire        outputStateA,      // output state A
  output wire        outputStateB,      // output state B
  output wire        pinOutA,           // pin A output value
  output wire        pinOutB,           // pin B output value
  output wire        pinOeA_n,          // pin A enable, low while driving
  output wire        pinOeB_n           // pin B enable, low while driving
);

  // ========================================================================
  // mode decoding
  function isPwm;
    input [3:0] m;
    begin
      isPwm = (m != `OCU_MODE_NORMAL) && (m != `OCU_MODE_CTC_CMPA) &&
              (m != `OCU_MODE_CTC_CAP) && (m != `OCU_MODE_RSVD);
    end
  endfunction

  function isFast;
    input [3:0] m;
    begin
      isFast = (m == `OCU_MODE_FAST8) || (m == `OCU_MODE_FAST9) ||
               (m == `OCU_MODE_FAST10) || (m == `OCU_MODE_FAST_CAP) ||
               (m == `OCU_MODE_FAST_CMPA);
    end
  endfunction

  function [15:0] fixedMask;
    input [3:0] m;
    begin
      case (m)
        `OCU_MODE_PC8,  `OCU_MODE_FAST8:  fixedMask = `OCU_TOP8;
        `OCU_MODE_PC9,  `OCU_MODE_FAST9:  fixedMask = `OCU_TOP9;
        `OCU_MODE_PC10, `OCU_MODE_FAST10: fixedMask = `OCU_TOP10;
        default:                          fixedMask = `OCU_MAX;
      endcase
    end
  endfunction

  wire [3:0] mode;
  wire       pwmMode;
  wire       fastMode;
  wire       dualMode;
  wire       ctcMode;
  wire       pfcMode;
  reg  [15:0] topValue;

  assign mode     = waveformModeSelect;
  assign pwmMode  = isPwm(mode);
  assign fastMode = isFast(mode);
  assign dualMode = pwmMode && !fastMode;
  assign ctcMode  = (mode == `OCU_MODE_CTC_CMPA) || (mode == `OCU_MODE_CTC_CAP);
  assign pfcMode  = (mode == `OCU_MODE_PFC_CAP) || (mode == `OCU_MODE_PFC_CMPA);

  wire [15:0] cmpA;
  wire [15:0] cmpB;

  always @*
  begin
    case (mode)
      `OCU_MODE_PC8,  `OCU_MODE_FAST8:  topValue = `OCU_TOP8;
      `OCU_MODE_PC9,  `OCU_MODE_FAST9:  topValue = `OCU_TOP9;
      `OCU_MODE_PC10, `OCU_MODE_FAST10: topValue = `OCU_TOP10;
      `OCU_MODE_CTC_CMPA, `OCU_MODE_PFC_CMPA,
      `OCU_MODE_PC_CMPA,  `OCU_MODE_FAST_CMPA:
        topValue = cmpA;
      `OCU_MODE_PFC_CAP, `OCU_MODE_PC_CAP,
      `OCU_MODE_CTC_CAP, `OCU_MODE_FAST_CAP:
        topValue = captureValue;
      default:                          topValue = `OCU_MAX;
    endcase
  end

  // ========================================================================
  // shared high-byte latch
  reg  [7:0] tempHigh_r;
  wire [15:0] wrWord;

  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      tempHigh_r <= `OCU_RST_TEMP;
    else if (wrCountHigh || wrCompareHighA || wrCompareHighB)
      tempHigh_r <= cpuWrData;
  end

  assign wrWord = {tempHigh_r, cpuWrData};

  // ========================================================================
  // match blocking after a counter write
  reg block_r;

  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      block_r <= 1'b0;
    else if (wrCountLow)
      block_r <= 1'b1;
    else if (timerClkEn)
      block_r <= 1'b0;
  end

  // ========================================================================
  // counter
  reg         countDown_r;
  wire        atTop;
  wire        atBottom;
  wire        topHit;
  wire        bottomHit;
  wire        wrapHit;
  wire        tick;

  assign tick      = timerClkEn && !wrCountLow;
  assign atTop     = (timerCount == topValue) && !block_r;
  assign atBottom  = (timerCount == `OCU_BOTTOM);
  assign topHit    = tick && atTop && (fastMode || ctcMode || (dualMode && !countDown_r));
  assign bottomHit = tick && dualMode && countDown_r && (timerCount == 16'h0001);
  assign wrapHit   = tick && !pwmMode && (timerCount == `OCU_MAX) && !(ctcMode && atTop);

  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      timerCount  <= `OCU_RST_COUNT;
      countDown_r <= 1'b0;
    end
    else if (wrCountLow)
      timerCount <= wrWord;
    else if (tick)
    begin
      if (dualMode)
      begin
        if (!countDown_r && atTop)
        begin
          countDown_r <= 1'b1;
          timerCount  <= timerCount - 16'h0001;
        end
        else if (countDown_r && atBottom)
        begin
          countDown_r <= 1'b0;
          timerCount  <= timerCount + 16'h0001;
        end
        else if (countDown_r)
          timerCount <= timerCount - 16'h0001;
        else
          timerCount <= timerCount + 16'h0001;
      end
      else
      begin
        countDown_r <= 1'b0;
        if ((fastMode || ctcMode) && atTop)
          timerCount <= `OCU_BOTTOM;
        else
          timerCount <= timerCount + 16'h0001;
      end
    end
  end

  // ========================================================================
  // overflow flag
  wire ovfSet;

  assign ovfSet = wrapHit || (fastMode && topHit) || bottomHit;

  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      overflowFlag <= 1'b0;
    else if (ovfSet)
      overflowFlag <= 1'b1;
    else if (clrOverflowFlag || irqAckOvf)
      overflowFlag <= 1'b0;
  end

  assign overflowIrq = overflowFlag && overflowIrqEnable;

  // ========================================================================
  // compare storage, updated at TOP in fast and phase correct, BOTTOM in pfc
  wire loadEvt;

  assign loadEvt = pfcMode ? bottomHit : topHit;

  ocu_cmp_reg uCmpA (
    .mclk     (mclk),
    .arst_n   (arst_n),
    .wrLow    (wrCompareLowA),
    .wrWord   (wrWord),
    .topMask  (fixedMask(mode)),
    .dblBuf   (pwmMode),
    .loadEvt  (loadEvt),
    .bufValue (compareValueA),
    .cmpValue (cmpA)
  );

  ocu_cmp_reg uCmpB (
    .mclk     (mclk),
    .arst_n   (arst_n),
    .wrLow    (wrCompareLowB),
    .wrWord   (wrWord),
    .topMask  (fixedMask(mode)),
    .dblBuf   (pwmMode),
    .loadEvt  (loadEvt),
    .bufValue (compareValueB),
    .cmpValue (cmpB)
  );

  // ========================================================================
  // per-channel match and output state
  wire [31:0] cmpVec;
  wire [3:0]  actVec;
  wire [1:0]  forceVec;
  wire [1:0]  portVec;
  wire [1:0]  dirVec;
  wire [1:0]  matchHit;
  wire [1:0]  ocState;

  assign cmpVec   = {cmpB, cmpA};
  assign actVec   = {outputActionBitsB, outputActionBitsA};
  assign forceVec = {forceMatchStrobeB, forceMatchStrobeA};
  assign portVec  = {portValueB, portValueA};
  assign dirVec   = {outputPinDirB, outputPinDirA};

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : gChan
      wire [1:0] act;
      wire       forced;
      reg        ocState_r;
      reg        ocState_nxt;

      assign act         = actVec[2*g+1:2*g];
      assign forced      = forceVec[g] && !pwmMode;
      assign matchHit[g] = tick && !block_r &&
                           (timerCount == cmpVec[16*g+15:16*g]);
      assign ocState[g]  = ocState_r;

      always @*
      begin
        ocState_nxt = ocState_r;
        if (!pwmMode)
        begin
          if (matchHit[g] || forced)
          begin
            case (act)
              `OCU_ACT_TOGGLE: ocState_nxt = ~ocState_r;
              `OCU_ACT_CLEAR:  ocState_nxt = 1'b0;
              `OCU_ACT_SET:    ocState_nxt = 1'b1;
              default:         ocState_nxt = ocState_r;
            endcase
          end
        end
        else if (fastMode)
        begin
          if (matchHit[g])
          begin
            if (act == `OCU_ACT_CLEAR)
              ocState_nxt = 1'b1;
            else if (act == `OCU_ACT_SET)
              ocState_nxt = 1'b0;
          end
          else if (topHit)
          begin
            if (act == `OCU_ACT_CLEAR)
              ocState_nxt = 1'b0;
            else if (act == `OCU_ACT_SET)
              ocState_nxt = 1'b1;
          end
        end
        else if (matchHit[g])
        begin
          if (act == `OCU_ACT_CLEAR)
            ocState_nxt = countDown_r;
          else if (act == `OCU_ACT_SET)
            ocState_nxt = !countDown_r;
        end
      end

      always @(posedge mclk or negedge arst_n)
      begin
        if (!arst_n)
          ocState_r <= `OCU_RST_STATE;
        else
          ocState_r <= ocState_nxt;
      end
    end
  endgenerate

  // ========================================================================
  // match flags, set wins over clear
  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      compareMatchFlagA <= 1'b0;
      compareMatchFlagB <= 1'b0;
    end
    else
    begin
      if (matchHit[0])
        compareMatchFlagA <= 1'b1;
      else if (clrMatchFlagA || irqAckA)
        compareMatchFlagA <= 1'b0;
      if (matchHit[1])
        compareMatchFlagB <= 1'b1;
      else if (clrMatchFlagB || irqAckB)
        compareMatchFlagB <= 1'b0;
    end
  end

  assign compareIrqA = compareMatchFlagA && compareIrqEnableA;
  assign compareIrqB = compareMatchFlagB && compareIrqEnableB;

  // ========================================================================
  // pin override
  assign outputStateA = ocState[0];
  assign outputStateB = ocState[1];
  assign pinOutA  = (actVec[1:0] != `OCU_ACT_NONE) ? ocState[0] : portVec[0];
  assign pinOutB  = (actVec[3:2] != `OCU_ACT_NONE) ? ocState[1] : portVec[1];
  assign pinOeA_n = ~dirVec[0];
  assign pinOeB_n = ~dirVec[1];

endmodule
`default_nettype wire

// ---- dv/ocu_timer_chk.sv ----
/* Checker of the output compare unit: channel A, counter and pin A.
   Assumes binding to ocu_timer with one clock domain. */
`default_nettype none
module ocu_timer_chk (
  input wire logic        mclk,               // clock
  input wire logic        arst_n,             // reset
  input wire logic        timerClkEn,         // tick
  input wire logic        wrCountLow,         // counter write
  input wire logic [3:0]  waveformModeSelect, // mode
  input wire logic [1:0]  outputActionBitsA,  // action A
  input wire logic        forceMatchStrobeA,  // force A
  input wire logic        compareIrqEnableA,  // irq enable A
  input wire logic        clrMatchFlagA,      // flag clear A
  input wire logic        irqAckA,            // irq ack A
  input wire logic        portValueA,         // port value A
  input wire logic        outputPinDirA,      // direction A
  input wire logic [15:0] timerCount,         // counter
  input wire logic [15:0] compareValueA,      // compare A
  input wire logic        compareMatchFlagA,  // flag A
  input wire logic        overflowFlag,       // overflow flag
  input wire logic        compareIrqA,        // irq A
  input wire logic        outputStateA,       // state A
  input wire logic        pinOutA,            // pin A
  input wire logic        pinOeA_n            // pin enable A
);
  timeunit 1ns;
  timeprecision 1ps;
  logic      blockPend_r;
  wire logic normTick = timerClkEn && !wrCountLow && waveformModeSelect == 4'h0;

  // a counter write waits for the tick that it blanks
  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
      blockPend_r <= 1'b0;
    else if (wrCountLow)
      blockPend_r <= 1'b1;
    else if (timerClkEn)
      blockPend_r <= 1'b0;

  // ==========================================================================
  // properties
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);

  a_match_sets_flag:
  assert property (normTick && !blockPend_r && timerCount == compareValueA
    |=> compareMatchFlagA) else $error("match flag A missed");
  a_write_blocks_match:
  assert property (normTick && blockPend_r && !compareMatchFlagA |=> !compareMatchFlagA)
    else $error("blocked match set flag A");
  a_irq_follows_flag:
  assert property (compareIrqA == (compareMatchFlagA && compareIrqEnableA))
    else $error("irq A not flag and enable");
  a_flag_clears:
  assert property (compareMatchFlagA && (clrMatchFlagA || irqAckA) && !timerClkEn
    |=> !compareMatchFlagA) else $error("flag A not cleared");
  a_force_no_flag:
  assert property (forceMatchStrobeA && !timerClkEn && !compareMatchFlagA &&
    waveformModeSelect == 4'h0 && outputActionBitsA == 2'h1
    |=> !compareMatchFlagA && outputStateA != $past(outputStateA))
    else $error("force A wrong");
  a_action_zero_holds:
  assert property (outputActionBitsA == 2'h0 |=> outputStateA == $past(outputStateA))
    else $error("state A moved with action zero");
  a_pin_override:
  assert property (pinOutA == (outputActionBitsA != 2'h0 ? outputStateA : portValueA)
    && pinOeA_n == !outputPinDirA) else $error("pin A source wrong");
  a_count_wraps:
  assert property (normTick && timerCount == 16'hffff
    |=> timerCount == 16'h0000 && overflowFlag) else $error("overflow missed");
  a_count_increments:
  assert property (normTick |=> timerCount == 16'($past(timerCount) + 16'h1))
    else $error("counter not incremented");
endmodule

bind ocu_timer ocu_timer_chk chk (.mclk, .arst_n, .timerClkEn, .wrCountLow,
  .waveformModeSelect, .outputActionBitsA, .forceMatchStrobeA, .compareIrqEnableA,
  .clrMatchFlagA, .irqAckA, .portValueA, .outputPinDirA, .timerCount, .compareValueA,
  .compareMatchFlagA, .overflowFlag, .compareIrqA, .outputStateA, .pinOutA, .pinOeA_n);
`default_nettype wire

// ---- dv/ocu_cpu_model.sv ----
/* CPU side of the unit: byte writes of counter and compare values.
   Assumes the unit samples its strobes on the rising edge of mclk. */
`default_nettype none
module ocu_cpu_model (
  input  wire logic       mclk,           // clock
  output wire logic [7:0] cpuWrData,      // write data
  output wire logic       wrCountHigh,    // counter high
  output wire logic       wrCountLow,     // counter low
  output wire logic       wrCompareHighA, // compare A high
  output wire logic       wrCompareLowA,  // compare A low
  output wire logic       wrCompareHighB, // compare B high
  output wire logic       wrCompareLowB   // compare B low
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] strb = 6'h00;
  logic [7:0] data = 8'h00;
  assign cpuWrData = data;
  assign {wrCompareLowB, wrCompareHighB, wrCompareLowA, wrCompareHighA, wrCountLow,
          wrCountHigh} = strb;

  // ==========================================================================
  // target 0 counter, 1 compare A, 2 compare B; data scrambled when idle
  task automatic writeByte(input logic [1:0] tgt, input logic low, input logic [7:0] d);
    @(negedge mclk);
    strb = 6'h01 << {tgt, low};
    data = d;
    @(negedge mclk);
    strb = 6'h00;
    data = ~d;
  endtask

  task automatic write16(input logic [1:0] tgt, input logic [15:0] v);
    writeByte(tgt, 1'b0, v[15:8]);
    writeByte(tgt, 1'b1, v[7:0]);
  endtask
endmodule
`default_nettype wire

// ---- dv/ocu_timer_bench.sv ----
/* Self-checking bench of the output compare unit.
   Assumes ocu_timer, its checker and the CPU model are compiled first. */
`default_nettype none
`define CHK(n, e, g) check(n, e, g)
module ocu_timer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0, arst_n = 1'b0, timerClkEn = 1'b0, expA = 1'b1;
  logic [3:0] waveformModeSelect = 4'h0;
  logic [1:0] outputActionBitsA = 2'h0, outputActionBitsB = 2'h0;
  logic forceMatchStrobeA = 0, forceMatchStrobeB = 0, compareIrqEnableA = 0,
    compareIrqEnableB = 0, overflowIrqEnable = 0, clrMatchFlagA = 0, clrMatchFlagB = 0,
    clrOverflowFlag = 0, irqAckA = 0, irqAckB = 0, irqAckOvf = 0, portValueA = 1,
    portValueB = 0, outputPinDirA = 0, outputPinDirB = 0;
  logic [15:0] captureValue = 16'h0000;
  wire [7:0] cpuWrData;
  wire [15:0] timerCount, compareValueA, compareValueB;
  wire wrCountHigh, wrCountLow, wrCompareHighA, wrCompareLowA, wrCompareHighB,
    wrCompareLowB, compareMatchFlagA, compareMatchFlagB, overflowFlag, compareIrqA,
    compareIrqB, overflowIrq, outputStateA, outputStateB, pinOutA, pinOutB, pinOeA_n,
    pinOeB_n;
  int errorCnt = 0, nCompared = 0;

  ocu_timer DUT (.mclk, .arst_n, .timerClkEn, .cpuWrData, .wrCountHigh, .wrCountLow,
    .wrCompareHighA, .wrCompareLowA, .wrCompareHighB, .wrCompareLowB, .waveformModeSelect,
    .outputActionBitsA, .outputActionBitsB, .forceMatchStrobeA, .forceMatchStrobeB,
    .compareIrqEnableA, .compareIrqEnableB, .overflowIrqEnable, .clrMatchFlagA,
    .clrMatchFlagB, .clrOverflowFlag, .irqAckA, .irqAckB, .irqAckOvf, .captureValue,
    .portValueA, .portValueB, .outputPinDirA, .outputPinDirB, .timerCount, .compareValueA,
    .compareValueB, .compareMatchFlagA, .compareMatchFlagB, .overflowFlag, .compareIrqA,
    .compareIrqB, .overflowIrq, .outputStateA, .outputStateB, .pinOutA, .pinOutB,
    .pinOeA_n, .pinOeB_n);
  ocu_cpu_model cpu (.mclk, .cpuWrData, .wrCountHigh, .wrCountLow, .wrCompareHighA,
    .wrCompareLowA, .wrCompareHighB, .wrCompareLowB);

  initial
    forever #12.5ns mclk = ~mclk;

  // ==========================================================================
  // tasks
  task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
    nCompared++;
    if (g !== e)
    begin
      errorCnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic results;
    if (errorCnt == 0 && nCompared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic pulse(ref logic s);
    @(negedge mclk) s = 1'b1;
    @(negedge mclk) s = 1'b0;
  endtask

  task automatic ticks(input int n);
    repeat (n)
      pulse(timerClkEn);
  endtask

  initial
  begin
    #100us;
    errorCnt++;
    results;
  end

  // ==========================================================================
  // main sequence
  initial
  begin
    repeat (12) @(posedge mclk);
    @(negedge mclk) arst_n = 1'b1;
    `CHK("stateA", 1'b0, outputStateA);
    `CHK("pinA", 1'b1, pinOutA);
    cpu.write16(2'd1, 16'h1234);
    `CHK("cmpA", 16'h1234, compareValueA);
    cpu.writeByte(2'd0, 1'b0, 8'h00);
    cpu.writeByte(2'd2, 1'b1, 8'h50);
    `CHK("cmpB latch", 16'h0050, compareValueB);
    compareIrqEnableA = 1'b1;
    outputActionBitsA = 2'h1;
    cpu.write16(2'd0, 16'h1232);
    ticks(2);
    `CHK("count", 16'h1234, timerCount);
    `CHK("flagA early", 1'b0, compareMatchFlagA);
    ticks(1);
    `CHK("flagA", 1'b1, compareMatchFlagA);
    `CHK("irqA", 1'b1, compareIrqA);
    `CHK("stateA toggle", 1'b1, outputStateA);
    pulse(irqAckA);
    `CHK("flagA ack", 1'b0, compareMatchFlagA);
    cpu.write16(2'd0, 16'h1234);
    repeat (3) @(negedge mclk);
    ticks(1);
    `CHK("flagA blocked", 1'b0, compareMatchFlagA);
    `CHK("count blocked", 16'h1235, timerCount);
    for (int a = 0; a < 4; a++)
    begin
      outputActionBitsA = 2'(a);
      expA = (a == 0) ? expA : (a == 1) ? !expA : (a == 3);
      cpu.write16(2'd0, 16'h1233);
      ticks(2);
      `CHK("stateA action", expA, outputStateA);
      pulse(clrMatchFlagA);
      `CHK("flagA clear", 1'b0, compareMatchFlagA);
    end
    outputActionBitsA = 2'h1;
    pulse(forceMatchStrobeA);
    `CHK("stateA force", 1'b0, outputStateA);
    `CHK("flagA force", 1'b0, compareMatchFlagA);
    outputActionBitsB = 2'h3;
    pulse(forceMatchStrobeB);
    outputPinDirB = 1'b1;
    @(negedge mclk);
    `CHK("pinB", 1'b1, pinOutB);
    `CHK("oeB", 1'b0, pinOeB_n);
    overflowIrqEnable = 1'b1;
    cpu.write16(2'd0, 16'hffff);
    ticks(1);
    `CHK("count wrap", 16'h0000, timerCount);
    `CHK("ovf irq", 1'b1, overflowIrq);
    pulse(clrOverflowFlag);
    `CHK("ovf clear", 1'b0, overflowFlag);
    waveformModeSelect = 4'h5;
    cpu.write16(2'd2, 16'h0060);
    `CHK("cmpB buffer", 16'h0060, compareValueB);
    `CHK("stateB kept", 1'b1, outputStateB);
    cpu.write16(2'd0, 16'h004f);
    ticks(2);
    `CHK("flagB old cmp", 1'b1, compareMatchFlagB);
    `CHK("stateB match", 1'b0, outputStateB);
    cpu.write16(2'd0, 16'h00fe);
    ticks(2);
    `CHK("count top", 16'h0000, timerCount);
    `CHK("stateB top", 1'b1, outputStateB);
    pulse(irqAckOvf);
    `CHK("ovf ack", 1'b0, overflowFlag);
    pulse(clrMatchFlagB);
    ticks(16'h60);
    `CHK("flagB no old", 1'b0, compareMatchFlagB);
    ticks(1);
    `CHK("flagB new cmp", 1'b1, compareMatchFlagB);
    `CHK("irqB off", 1'b0, compareIrqB);
    waveformModeSelect = 4'h4;
    cpu.write16(2'd0, 16'h1233);
    ticks(2);
    `CHK("count ctc", 16'h0000, timerCount);
    captureValue = 16'h0100;
    waveformModeSelect = 4'ha;
    cpu.write16(2'd0, 16'h00ff);
    ticks(3);
    `CHK("count dual", 16'h00fe, timerCount);
    results;
  end
endmodule
`default_nettype wire
